//--- verilog/acc_pkg.sv
/*
  shared constants of the converter channel control block: register
  indices, field positions, reset values and field codes.
  assumes a wishbone slave with 32-bit data, one register per word.
*/
package acc_pkg;
  // register indices, byte address is four times the index
  localparam logic [3:0] ACC_IDX_CTRL = 4'h0;
  localparam logic [3:0] ACC_IDX_MUX = 4'h1;
  localparam logic [3:0] ACC_IDX_INTCTL = 4'h2;
  localparam logic [3:0] ACC_IDX_FLAG = 4'h3;
  localparam logic [3:0] ACC_IDX_GCTRL = 4'h4;
  localparam logic [3:0] ACC_IDX_GFLAG = 4'h5;
  // channel control fields
  localparam int ACC_START_BIT = 7;
  localparam int ACC_GAIN_LSB = 2;
  localparam int ACC_MODE_LSB = 0;
  // input select fields
  localparam int ACC_POS_LSB = 3;
  localparam int ACC_NEG_LSB = 0;
  // interrupt control fields
  localparam int ACC_IMODE_LSB = 2;
  localparam int ACC_ILVL_LSB = 0;
  // flag bit and the start field of the global control register
  localparam int ACC_FLAG_BIT = 0;
  localparam int ACC_GSTART_LSB = 2;
  // reset values
  localparam logic [7:0] ACC_CTRL_RST = 8'h00;
  localparam logic [7:0] ACC_MUX_RST = 8'h00;
  localparam logic [7:0] ACC_INTCTL_RST = 8'h00;
  // input modes
  localparam logic [1:0] ACC_MODE_INTERNAL = 2'h0;
  localparam logic [1:0] ACC_MODE_SINGLE = 2'h1;
  localparam logic [1:0] ACC_MODE_DIFF = 2'h2;
  localparam logic [1:0] ACC_MODE_DIFFWG = 2'h3;
  // interrupt conditions
  localparam logic [1:0] ACC_IC_COMPLETE = 2'h0;
  localparam logic [1:0] ACC_IC_BELOW = 2'h1;
  localparam logic [1:0] ACC_IC_ABOVE = 2'h3;
  // gain code that is reserved, and the highest internal source
  localparam logic [2:0] ACC_GAIN_RSVD = 3'h7;
  localparam logic [2:0] ACC_INT_SRC_MAX = 3'h3;
  // negative pin base for differential with gain
  localparam logic [2:0] ACC_NEG_GAIN_BASE = 3'h4;
  // start request state
  typedef enum logic [1:0] {
    ACC_ST_IDLE = 2'b01,
    ACC_ST_PEND = 2'b10
  } acc_start_t;
endpackage

//--- verilog/acc_channel_control.sv
/*
  one channel of a multi-channel converter: registers on a classic
  wishbone slave, input and gain selection, start request and flag.
  assumes the conversion core reports begin and completion as single
  cycle pulses and the interrupt controller pulses an acknowledge.
  assumes software writes zeros to reserved bits and picks the
  differential modes only while the converter converts signed.
*/
`timescale 1ns/100ps
module acc_channel_control #(
  parameter int CH_INDEX = 0,
  parameter int MUX_INPUTS = 16
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [5:2] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // converter global state and compare value
  input wire logic signed_conversion_select_i,
  input wire logic [15:0] compare_value_i,
  // conversion core
  output logic conv_req_o,
  input wire logic conv_begun_i,
  input wire logic conv_done_i,
  input wire logic [15:0] result_i,
  // analog selection
  output logic [6:0] gain_factor_o,
  output logic gain_path_o,
  output logic pos_internal_o,
  output logic [1:0] pos_source_o,
  output logic [3:0] pos_pin_o,
  output logic neg_fixed_o,
  output logic [2:0] neg_pin_o,
  output logic sel_reserved_o,
  // interrupt controller
  output logic irq_o,
  output logic [1:0] irq_level_o,
  input wire logic irq_ack_i
);
  import acc_pkg::*;

  acc_start_t start_q;
  logic ack_q;
  logic [31:0] dat_q;
  logic [2:0] gain_q;
  logic [1:0] mode_q;
  logic [3:0] pos_q;
  logic [1:0] neg_q;
  logic [1:0] imode_q;
  logic [1:0] ilvl_q;
  logic flag_q;
  logic req_rd;
  logic req_wr;
  logic start_set;
  logic flag_clr;
  logic hit_below;
  logic hit_above;
  logic flag_set;
  logic [7:0] rd_byte;
  logic [6:0] gain_d;
  logic [3:0] pos_pin_d;
  logic [2:0] neg_pin_d;
  logic rsvd_d;
  logic [3:0] pos_mask;

  // true when the word address names the given register index
  function automatic logic hit(input logic [3:0] a, input logic [3:0] idx);
    hit = (a == idx);
  endfunction

  // a request is read at the first edge and written at the ack edge
  assign req_rd = cyc_i & stb_i & ~ack_q;
  assign req_wr = cyc_i & stb_i & we_i & ack_q & sel_i[0];
  assign ack_o = ack_q;
  assign dat_o = dat_q;

  // ack for one cycle per request, then drop it; the slave never
  // stalls, so a master holding cyc and stb sees ack after one edge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req_rd;
    end
  end

  // start can be set through the channel or the global alias;
  // both views feed one request, so they can never disagree
  always_comb begin
    start_set = 1'b0;
    if (req_wr) begin
      if (hit(adr_i, ACC_IDX_CTRL)) begin
        start_set = dat_i[ACC_START_BIT];
      end else if (hit(adr_i, ACC_IDX_GCTRL)) begin
        start_set = dat_i[ACC_GSTART_LSB + CH_INDEX];
      end
    end
  end

  // start request: pending until the core reports it has begun;
  // a write in the begin cycle is against a pending bit, so it is lost
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      start_q <= ACC_ST_IDLE;
    end else begin
      case (start_q)
        ACC_ST_IDLE: begin
          if (start_set) begin
            start_q <= ACC_ST_PEND;
          end
        end
        ACC_ST_PEND: begin
          if (conv_begun_i) begin
            start_q <= ACC_ST_IDLE;
          end
        end
        default: begin
          start_q <= ACC_ST_IDLE;
        end
      endcase
    end
  end

  // a second write while pending just leaves the state alone;
  // the core sees a level, not a pulse, so a slow core cannot miss it
  assign conv_req_o = (start_q == ACC_ST_PEND);

  // channel control fields; reserved bits 6:5 are not stored, so
  // they read zero whatever software wrote there
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      gain_q <= ACC_CTRL_RST[ACC_GAIN_LSB +: 3];
      mode_q <= ACC_CTRL_RST[ACC_MODE_LSB +: 2];
    end else if (req_wr && hit(adr_i, ACC_IDX_CTRL)) begin
      gain_q <= dat_i[ACC_GAIN_LSB +: 3];
      mode_q <= dat_i[ACC_MODE_LSB +: 2];
    end
  end

  // input selection; reserved bits 7 and 2 are not stored
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pos_q <= ACC_MUX_RST[ACC_POS_LSB +: 4];
      neg_q <= ACC_MUX_RST[ACC_NEG_LSB +: 2];
    end else if (req_wr && hit(adr_i, ACC_IDX_MUX)) begin
      pos_q <= dat_i[ACC_POS_LSB +: 4];
      neg_q <= dat_i[ACC_NEG_LSB +: 2];
    end
  end

  // interrupt condition and level; the upper nibble is not stored
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      imode_q <= ACC_INTCTL_RST[ACC_IMODE_LSB +: 2];
      ilvl_q <= ACC_INTCTL_RST[ACC_ILVL_LSB +: 2];
    end else if (req_wr && hit(adr_i, ACC_IDX_INTCTL)) begin
      imode_q <= dat_i[ACC_IMODE_LSB +: 2];
      ilvl_q <= dat_i[ACC_ILVL_LSB +: 2];
    end
  end

  // compare against the threshold, signed only in signed mode;
  // an unsigned compare would rank negative results above positive ones
  always_comb begin
    if (signed_conversion_select_i) begin
      hit_below = $signed(result_i) < $signed(compare_value_i);
      hit_above = $signed(result_i) > $signed(compare_value_i);
    end else begin
      hit_below = result_i < compare_value_i;
      hit_above = result_i > compare_value_i;
    end
  end

  // flag cause follows the selected condition; 10 never sets it;
  // the result is only trusted in the cycle of the done pulse
  always_comb begin
    flag_set = 1'b0;
    if (conv_done_i) begin
      case (imode_q)
        ACC_IC_COMPLETE: flag_set = 1'b1;
        ACC_IC_BELOW: flag_set = hit_below;
        ACC_IC_ABOVE: flag_set = hit_above;
        default: flag_set = 1'b0;
      endcase
    end
  end

  // clear by vector acknowledge or by a one in either flag view;
  // the acknowledge comes from the interrupt controller, not the bus
  always_comb begin
    flag_clr = irq_ack_i;
    if (req_wr) begin
      if (hit(adr_i, ACC_IDX_FLAG)) begin
        flag_clr = flag_clr | dat_i[ACC_FLAG_BIT];
      end else if (hit(adr_i, ACC_IDX_GFLAG)) begin
        flag_clr = flag_clr | dat_i[CH_INDEX];
      end
    end
  end

  // the flag: a new event wins over a clear in the same cycle, so a
  // completion is never lost; software then simply sees it set again
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flag_q <= 1'b0;
    end else if (flag_set) begin
      flag_q <= 1'b1;
    end else if (flag_clr) begin
      flag_q <= 1'b0;
    end
  end

  // request raised while flag is set and level is nonzero; registered
  // so the controller never sees a glitch while the level changes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
      irq_level_o <= 2'h0;
    end else begin
      irq_o <= flag_q & (ilvl_q != 2'h0);
      irq_level_o <= ilvl_q;
    end
  end

  // read mux; unmapped indices and reserved bits read zero;
  // the alias views show only this channel's bit, the rest is elsewhere
  always_comb begin
    rd_byte = 8'h00;
    if (hit(adr_i, ACC_IDX_CTRL)) begin
      rd_byte[ACC_START_BIT] = conv_req_o;
      rd_byte[ACC_GAIN_LSB +: 3] = gain_q;
      rd_byte[ACC_MODE_LSB +: 2] = mode_q;
    end else if (hit(adr_i, ACC_IDX_MUX)) begin
      rd_byte[ACC_POS_LSB +: 4] = pos_q;
      rd_byte[ACC_NEG_LSB +: 2] = neg_q;
    end else if (hit(adr_i, ACC_IDX_INTCTL)) begin
      rd_byte[ACC_IMODE_LSB +: 2] = imode_q;
      rd_byte[ACC_ILVL_LSB +: 2] = ilvl_q;
    end else if (hit(adr_i, ACC_IDX_FLAG)) begin
      rd_byte[ACC_FLAG_BIT] = flag_q;
    end else if (hit(adr_i, ACC_IDX_GCTRL)) begin
      rd_byte[ACC_GSTART_LSB + CH_INDEX] = conv_req_o;
    end else if (hit(adr_i, ACC_IDX_GFLAG)) begin
      rd_byte[CH_INDEX] = flag_q;
    end
  end

  // read data is captured at the request edge and held during ack;
  // a flag that sets during the ack cycle shows on the next read
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_q <= 32'h0000_0000;
    end else if (req_rd) begin
      dat_q <= {24'h00_0000, rd_byte};
    end
  end

  // gain code n amplifies by two to the n; reserved code gives none
  // and is reported on the reserved selection output as well
  always_comb begin
    gain_d = 7'h00;
    if (gain_q != ACC_GAIN_RSVD) begin
      gain_d = 7'h01 << gain_q;
    end
  end

  // top positive bit only exists on parts with wide multiplexers;
  // on narrow parts codes 8 and up alias pins 0 to 7
  assign pos_mask = (MUX_INPUTS > 8) ? 4'hf : 4'h7;

  // mux decode; the mode field is honoured whatever the signed setting,
  // differential codes are only legal when the converter is signed;
  // reserved selections still route, but software must not rely on them
  always_comb begin
    pos_pin_d = 4'h0;
    neg_pin_d = 3'h0;
    rsvd_d = 1'b0;
    case (mode_q)
      ACC_MODE_INTERNAL: begin
        rsvd_d = pos_q > {1'b0, ACC_INT_SRC_MAX};
      end
      ACC_MODE_SINGLE: begin
        pos_pin_d = pos_q & pos_mask;
      end
      ACC_MODE_DIFF: begin
        pos_pin_d = pos_q & pos_mask;
        neg_pin_d = {1'b0, neg_q};
        rsvd_d = ~signed_conversion_select_i;
      end
      ACC_MODE_DIFFWG: begin
        pos_pin_d = pos_q & pos_mask;
        neg_pin_d = ACC_NEG_GAIN_BASE | {1'b0, neg_q};
        rsvd_d = ~signed_conversion_select_i;
      end
      default: begin
        rsvd_d = 1'b1;
      end
    endcase
  end

  // gain outputs are registered to keep the analog switches glitch
  // free; they follow the register state one clock later
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      gain_factor_o <= 7'h01;
      gain_path_o <= 1'b0;
    end else begin
      gain_factor_o <= gain_d;
      gain_path_o <= (mode_q == ACC_MODE_DIFFWG);
    end
  end

  // positive input selection; the internal source code is passed on
  // in every mode, it only matters while the internal flag is high
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pos_internal_o <= 1'b1;
      pos_source_o <= 2'h0;
      pos_pin_o <= 4'h0;
    end else begin
      pos_internal_o <= (mode_q == ACC_MODE_INTERNAL);
      pos_source_o <= pos_q[1:0];
      pos_pin_o <= pos_pin_d;
    end
  end

  // negative input; the select field is ignored unless differential,
  // so a stale field cannot disturb a single ended measurement
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      neg_fixed_o <= 1'b1;
      neg_pin_o <= 3'h0;
    end else begin
      neg_fixed_o <= ~mode_q[1];
      neg_pin_o <= neg_pin_d;
    end
  end

  // reserved selection indicator, for software that wants to check
  // its own settings before starting a conversion
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sel_reserved_o <= 1'b0;
    end else begin
      sel_reserved_o <= rsvd_d | (gain_q == ACC_GAIN_RSVD);
    end
  end
endmodule // acc_channel_control

//--- sim/acc_channel_control_checker.sv
/* checker for the channel block: bus answer, start request and interrupt relations.
   assumes it is bound to the top module and sees its ports only. */
`timescale 1ns/100ps
module acc_channel_control_checker #(
  parameter int CH_INDEX = 0,
  parameter int MUX_INPUTS = 16
) (
  // clock, reset and bus
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [5:2] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  input wire logic ack_o,
  // core and interrupt
  input wire logic conv_req_o,
  input wire logic conv_begun_i,
  input wire logic conv_done_i,
  input wire logic irq_o,
  input wire logic [1:0] irq_level_o,
  input wire logic irq_ack_i,
  // analog selection
  input wire logic [6:0] gain_factor_o,
  input wire logic gain_path_o,
  input wire logic pos_internal_o,
  input wire logic [3:0] pos_pin_o,
  input wire logic neg_fixed_o,
  input wire logic [2:0] neg_pin_o
);
  import acc_pkg::*;
  logic wr_start;
  // a write edge carrying a start bit through either location
  assign wr_start = cyc_i && stb_i && we_i && ack_o && sel_i[0] &&
    ((adr_i == ACC_IDX_CTRL && dat_i[ACC_START_BIT]) ||
    (adr_i == ACC_IDX_GCTRL && dat_i[ACC_GSTART_LSB + CH_INDEX]));
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_ack_answer: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("bus request not answered next cycle");
  a_start_cause: assert property ($rose(conv_req_o) |-> $past(wr_start))
    else $error("start pending without a start write");
  a_start_clear: assert property (conv_req_o && conv_begun_i |=> !conv_req_o)
    else $error("start not cleared after begin");
  a_start_hold: assert property (conv_req_o && !conv_begun_i |=> conv_req_o)
    else $error("pending start lost before begin");
  a_level_zero: assert property (!(irq_o && irq_level_o == 2'h0))
    else $error("request raised with level zero");
  a_vector_clear: assert property (irq_ack_i && !conv_done_i |-> ##2 !irq_o)
    else $error("vector did not clear the request");
  a_gain_onehot: assert property ($onehot0(gain_factor_o))
    else $error("gain factor not a power of two");
  a_neg_unused: assert property (neg_fixed_o |-> neg_pin_o == 3'h0 && !gain_path_o)
    else $error("negative select used while fixed");
  a_internal_src: assert property (pos_internal_o |-> pos_pin_o == 4'h0 && neg_fixed_o)
    else $error("pin routed in internal mode");
  c_start: cover property ($rose(conv_req_o));
  c_irq: cover property ($rose(irq_o));
  c_vector: cover property (irq_ack_i && irq_o);
endmodule // acc_channel_control_checker

//--- sim/acc_core_model.sv
/* stand-in for the conversion core: waits, begins, waits, completes.
   assumes the channel holds its request until begin is seen. */
`timescale 1ns/100ps
module acc_core_model (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // channel side
  input wire logic conv_req_i,
  output logic conv_begun_o,
  output logic conv_done_o,
  output logic [15:0] result_o,
  // bench control: wait in cycles and next result
  input wire logic [3:0] lat_i,
  input wire logic [15:0] res_i
);
  logic [3:0] cnt_q;
  logic arm_q;
  logic busy_q;
  // one conversion at a time; result garbled outside the done pulse
  always_ff @(posedge clk_i) begin
    conv_begun_o <= 1'b0;
    conv_done_o <= 1'b0;
    result_o <= ~result_o;
    if (rst_i) begin
      cnt_q <= 4'h0;
      arm_q <= 1'b0;
      busy_q <= 1'b0;
      result_o <= 16'h0;
    end else if (cnt_q != 4'h0) begin
      cnt_q <= cnt_q - 4'h1;
    end else if (busy_q) begin
      conv_done_o <= 1'b1;
      busy_q <= 1'b0;
      result_o <= res_i;
    end else if (arm_q) begin
      conv_begun_o <= 1'b1;
      arm_q <= 1'b0;
      busy_q <= 1'b1;
      cnt_q <= lat_i;
    end else if (conv_req_i && !conv_begun_o) begin
      arm_q <= 1'b1;
      cnt_q <= lat_i;
    end
  end
endmodule // acc_core_model

//--- sim/acc_channel_control_tb_top.sv
/* bench for the channel block: bus tasks, core model, one task per scenario.
   assumes a 10 MHz clock and a synchronous reset. */
`timescale 1ns/100ps
module acc_channel_control_tb_top;
  import acc_pkg::*;
  logic clk_i, rst_i, cyc, stb, we, sgn, irq_ack, ack_o, conv_req, begun, done;
  logic gpath, pint, nfix, srsv, irq;
  logic [1:0] psrc, lvl;
  logic [3:0] adr, sel, lat, ppin;
  logic [2:0] npin;
  logic [6:0] gain;
  logic [15:0] cmpv, res, result;
  logic [31:0] dat, dat_o, q;
  int n_fail, num_checks, n_begun, n_done;
  acc_channel_control uut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
    .adr_i(adr), .sel_i(sel), .dat_i(dat), .dat_o(dat_o), .ack_o(ack_o),
    .signed_conversion_select_i(sgn), .compare_value_i(cmpv), .conv_req_o(conv_req),
    .conv_begun_i(begun), .conv_done_i(done), .result_i(result), .gain_factor_o(gain),
    .gain_path_o(gpath), .pos_internal_o(pint), .pos_source_o(psrc), .pos_pin_o(ppin),
    .neg_fixed_o(nfix), .neg_pin_o(npin), .sel_reserved_o(srsv), .irq_o(irq),
    .irq_level_o(lvl), .irq_ack_i(irq_ack));
  acc_core_model core (.clk_i(clk_i), .rst_i(rst_i), .conv_req_i(conv_req),
    .conv_begun_o(begun), .conv_done_o(done), .result_o(result), .lat_i(lat), .res_i(res));
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  // count core pulses so duplicate conversions show up
  always @(posedge clk_i) begin
    n_begun += int'(begun);
    n_done += int'(done);
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(negedge clk_i);
  endtask
  // classic cycle: hold everything until ack is sampled, then release
  task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'h1;
    dat <= {24'h0, d};
    @(posedge clk_i);
    while (ack_o !== 1'b1) @(posedge clk_i);
    q = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    wb(1'b1, a, d);
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    wb(1'b0, a, 8'h00);
    chk(q, e);
  endtask
  // start a conversion and wait for completion plus the request lag
  task automatic conv;
    int k;
    k = n_done;
    wr(ACC_IDX_CTRL, 8'h80);
    while (n_done == k) tick(1);
    tick(2);
  endtask
  task automatic t_reset;
    chk({gain, pint, nfix, conv_req, irq}, {7'h01, 4'hc});
    rd(ACC_IDX_MUX, {24'h0, ACC_MUX_RST});
    rd(ACC_IDX_FLAG, 32'h0);
    rd(4'hf, 32'h0);
  endtask
  task automatic t_gain;
    for (int g = 0; g < 8; g++) begin
      wr(ACC_IDX_CTRL, 8'(g << ACC_GAIN_LSB) | {6'h0, ACC_MODE_DIFFWG});
      tick(2);
      chk(gain, g == 7 ? 7'h00 : 7'(1 << g));
      chk(gpath, 1'b1);
    end
  endtask
  // positive field 4'hb and negative field 2'h2 under every input mode
  task automatic t_mux;
    logic [9:0] em [4];
    em = '{10'h211, 10'h170, 10'h164, 10'h16c};
    wr(ACC_IDX_MUX, 8'h5a);
    for (int m = 0; m < 4; m++) begin
      wr(ACC_IDX_CTRL, 8'(m));
      tick(2);
      chk({pint, ppin, nfix, npin, srsv}, em[m]);
      if (m == 0) chk(psrc, 2'h3);
    end
    @(posedge clk_i);
    sgn <= 1'b0;
    wr(ACC_IDX_CTRL, {6'h0, ACC_MODE_DIFF});
    tick(2);
    chk(srsv, 1'b1);
    rd(ACC_IDX_CTRL, 32'h2);
    wr(ACC_IDX_CTRL, 8'h01);
    wr(ACC_IDX_MUX, 8'h00);
  endtask
  task automatic t_start;
    lat <= 4'hf;
    n_begun = 0;
    wr(ACC_IDX_CTRL, 8'h80);
    rd(ACC_IDX_CTRL, 32'h80);
    rd(ACC_IDX_GCTRL, 32'h4);
    wr(ACC_IDX_CTRL, 8'h80);
    while (conv_req !== 1'b0) tick(1);
    tick(40);
    chk(n_begun, 1);
    rd(ACC_IDX_CTRL, 32'h0);
    lat <= 4'h0;
    wr(ACC_IDX_GCTRL, 8'h04);
    tick(1);
    chk(conv_req, 1'b1);
    tick(10);
    chk(n_begun, 2);
  endtask
  // condition, result against threshold 100, expected flag
  task automatic t_flag;
    logic [1:0] cc [6];
    logic [15:0] rv [6];
    logic ef [6];
    cc = '{ACC_IC_COMPLETE, ACC_IC_BELOW, ACC_IC_BELOW, ACC_IC_ABOVE, ACC_IC_ABOVE, 2'h2};
    rv = '{16'h32, 16'h32, 16'h96, 16'h96, 16'h32, 16'h32};
    ef = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0};
    for (int i = 0; i < 6; i++) begin
      wr(ACC_IDX_INTCTL, {4'h0, cc[i], 2'h2});
      res <= rv[i];
      conv;
      chk({irq, lvl}, {ef[i], 2'h2});
      rd(ACC_IDX_GFLAG, {31'h0, ef[i]});
      wr(ACC_IDX_FLAG, 8'h00);
      rd(ACC_IDX_FLAG, {31'h0, ef[i]});
      wr(ACC_IDX_FLAG, 8'h01);
      rd(ACC_IDX_FLAG, 32'h0);
    end
    wr(ACC_IDX_INTCTL, 8'h01);
    conv;
    chk(irq, 1'b1);
    @(posedge clk_i);
    irq_ack <= 1'b1;
    @(posedge clk_i);
    irq_ack <= 1'b0;
    tick(2);
    chk(irq, 1'b0);
    wr(ACC_IDX_INTCTL, 8'h00);
    conv;
    chk({irq, lvl}, 3'h0);
    wr(ACC_IDX_GFLAG, 8'h01);
    rd(ACC_IDX_FLAG, 32'h0);
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk_i);
    n_fail++;
    wrap_up();
  end
  initial begin
    {cyc, stb, we, irq_ack} = 4'h0;
    {adr, lat, sel} = 12'h001;
    dat = 32'h0;
    cmpv = 16'h64;
    res = 16'h0;
    sgn = 1'b1;
    rst_i = 1'b1;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    tick(1);
    t_reset();
    t_gain();
    t_mux();
    t_start();
    t_flag();
    wrap_up();
  end
endmodule // acc_channel_control_tb_top
bind acc_channel_control acc_channel_control_checker #(.CH_INDEX(CH_INDEX),
  .MUX_INPUTS(MUX_INPUTS)) chk_i (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
  .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .ack_o(ack_o),
  .conv_req_o(conv_req_o), .conv_begun_i(conv_begun_i), .conv_done_i(conv_done_i),
  .irq_o(irq_o), .irq_level_o(irq_level_o), .irq_ack_i(irq_ack_i),
  .gain_factor_o(gain_factor_o), .gain_path_o(gain_path_o), .pos_internal_o(pos_internal_o),
  .pos_pin_o(pos_pin_o), .neg_fixed_o(neg_fixed_o), .neg_pin_o(neg_pin_o));
